// >>> eaie_pkg.sv
// Contract
// - immediate address add/sub/compare are four bytes
// - pc destination sees whole encoding consumed
// - move into pc gives plain result
// - prefixed 20-bit forms handle pc correctly
// - push of sp-indirect-increment: sp minus four
// - call through pc pushes correct return
// - call index on sp sign-extended to 20
// - handler instruction decodes at own width
`default_nettype none
package eaie_pkg;
    localparam int unsigned AW = 20;
    localparam int unsigned DW = 16;
    localparam int unsigned HIW = AW - DW;

    // opcode field of the first word
    localparam int unsigned OPC_HI = 15;
    localparam int unsigned OPC_LO = 12;
    localparam int unsigned IMMX_HI = 11;
    localparam int unsigned IMMX_LO = 8;
    localparam int unsigned DST_HI = 3;
    localparam int unsigned DST_LO = 0;
    localparam int unsigned LPM_BIT = 4;

    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_ADD_IMM = 4'h1;
    localparam logic [3:0] OP_SUB_IMM = 4'h2;
    localparam logic [3:0] OP_CMP_IMM = 4'h3;
    localparam logic [3:0] OP_MOV_IMM = 4'h4;
    localparam logic [3:0] OP_PUSH_SP_INC = 4'h5;
    localparam logic [3:0] OP_CALL_PC = 4'h6;
    localparam logic [3:0] OP_CALL_IDX_SP = 4'h7;
    localparam logic [3:0] OP_LPM_IDX = 4'h8;
    localparam logic [3:0] OP_PREFIX = 4'h9;

    localparam logic [3:0] REG_PC = 4'h0;
    localparam logic [3:0] REG_SP = 4'h1;

    localparam logic [19:0] WORD_STEP = 20'h00002;
    localparam logic [19:0] PUSH_STEP = 20'h00004;
    localparam logic [19:0] RESET_PC = 20'h00000;
    localparam logic [19:0] RESET_SP = 20'h01000;
    localparam logic [19:0] NMI_VECTOR = 20'h0ff00;

    typedef enum logic [2:0] {
        S_FETCH, S_EXT, S_EXEC, S_RD_LO, S_RD_HI, S_WR_LO, S_WR_HI, S_SLEEP
    } eaie_state_t;

    function automatic logic [19:0] addr_plus(input logic [19:0] a, input logic [19:0] b);
        addr_plus = a + b;
    endfunction

    function automatic logic needs_ext(input logic [3:0] op);
        needs_ext = (op == OP_ADD_IMM) || (op == OP_SUB_IMM) || (op == OP_CMP_IMM) ||
                    (op == OP_MOV_IMM) || (op == OP_CALL_IDX_SP) || (op == OP_LPM_IDX);
    endfunction
endpackage
`default_nettype wire

// >>> eaie_core.sv
`timescale 1ns/100ps
`default_nettype none
module eaie_core (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // memory port, one word per access
    output logic mem_req,
    output logic mem_we,
    output logic [19:0] mem_addr,
    output logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    // non-maskable request
    input wire logic nmi_req,
    output logic nmi_ack,
    // observed state
    output logic [19:0] pc,
    output logic [19:0] sp,
    output logic low_power,
    output logic flag_z,
    output logic flag_n,
    output logic flag_c,
    output logic insn_done
);
    eaie_pkg::eaie_state_t state, next_state;
    logic [19:0] regs [16];
    logic [19:0] next_regs [16];
    logic [19:0] next_pc, next_sp, data20, next_data20, target, next_target, ptr, next_ptr;
    logic [15:0] iw0, next_iw0, iw1, next_iw1, next_mem_wdata;
    logic [19:0] next_mem_addr;
    logic prefix, next_prefix, do_jump, next_do_jump, next_low_power, nmi_entry, next_nmi_entry;
    logic next_mem_req, next_mem_we, next_nmi_ack, next_insn_done;
    logic next_flag_z, next_flag_n, next_flag_c;
    logic [3:0] op, dst;
    logic [19:0] imm20, dst_val, sext_idx;
    logic [20:0] alu;
    logic take_nmi;

    assign op = iw0[eaie_pkg::OPC_HI:eaie_pkg::OPC_LO];
    assign dst = iw0[eaie_pkg::DST_HI:eaie_pkg::DST_LO];
    assign imm20 = {iw0[eaie_pkg::IMMX_HI:eaie_pkg::IMMX_LO], iw1};
    assign sext_idx = {{eaie_pkg::HIW{iw1[eaie_pkg::DW-1]}}, iw1};
    // pc here already points past every fetched word, prefix included
    assign dst_val = (dst == eaie_pkg::REG_PC) ? pc : regs[dst];
    assign take_nmi = nmi_req && ((state == eaie_pkg::S_FETCH && !mem_req && !prefix) || state == eaie_pkg::S_SLEEP);

    always_comb begin
        if (op == eaie_pkg::OP_ADD_IMM) begin
            alu = {1'b0, dst_val} + {1'b0, imm20};
        end else begin
            alu = {1'b0, dst_val} + {1'b0, ~imm20} + 21'h000001;
        end
    end

    always_comb begin
        next_state = state;
        next_regs = regs;
        next_pc = pc;
        next_sp = sp;
        next_iw0 = iw0;
        next_iw1 = iw1;
        next_data20 = data20;
        next_target = target;
        next_ptr = ptr;
        next_prefix = prefix;
        next_do_jump = do_jump;
        next_low_power = low_power;
        next_mem_req = mem_req;
        next_mem_we = mem_we;
        next_mem_addr = mem_addr;
        next_mem_wdata = mem_wdata;
        next_nmi_ack = 1'b0;
        next_insn_done = 1'b0;
        next_flag_z = flag_z;
        next_flag_n = flag_n;
        next_flag_c = flag_c;
        case (state)
            eaie_pkg::S_FETCH, eaie_pkg::S_EXT: begin
                if (take_nmi && state == eaie_pkg::S_FETCH) begin
                    // handler starts clean, no width left over from before
                    next_prefix = 1'b0;
                    next_data20 = pc;
                    next_target = eaie_pkg::NMI_VECTOR;
                    next_do_jump = 1'b1;
                    next_nmi_ack = 1'b1;
                    next_sp = sp - eaie_pkg::PUSH_STEP;
                    next_state = eaie_pkg::S_WR_LO;
                end else if (!mem_req) begin
                    next_mem_req = 1'b1;
                    next_mem_we = 1'b0;
                    next_mem_addr = pc;
                end else if (mem_ack) begin
                    next_mem_req = 1'b0;
                    next_pc = eaie_pkg::addr_plus(pc, eaie_pkg::WORD_STEP);
                    if (state == eaie_pkg::S_EXT) begin
                        next_iw1 = mem_rdata;
                        next_state = eaie_pkg::S_EXEC;
                    end else if (mem_rdata[eaie_pkg::OPC_HI:eaie_pkg::OPC_LO] == eaie_pkg::OP_PREFIX) begin
                        next_prefix = 1'b1;
                    end else begin
                        next_iw0 = mem_rdata;
                        next_state = eaie_pkg::needs_ext(mem_rdata[eaie_pkg::OPC_HI:eaie_pkg::OPC_LO]) ?
                                     eaie_pkg::S_EXT : eaie_pkg::S_EXEC;
                    end
                end
            end
            eaie_pkg::S_EXEC: begin
                next_state = eaie_pkg::S_FETCH;
                next_insn_done = 1'b1;
                next_prefix = 1'b0;
                case (op)
                    eaie_pkg::OP_ADD_IMM, eaie_pkg::OP_SUB_IMM, eaie_pkg::OP_CMP_IMM: begin
                        next_flag_z = (alu[19:0] == 20'h00000);
                        next_flag_n = alu[19];
                        next_flag_c = alu[20];
                        if (op != eaie_pkg::OP_CMP_IMM) begin
                            if (dst == eaie_pkg::REG_PC) begin
                                next_pc = alu[19:0];
                            end else if (dst == eaie_pkg::REG_SP) begin
                                next_sp = alu[19:0];
                            end else begin
                                next_regs[dst] = alu[19:0];
                            end
                        end
                    end
                    eaie_pkg::OP_MOV_IMM: begin
                        if (dst == eaie_pkg::REG_PC) begin
                            next_pc = imm20;
                        end else if (dst == eaie_pkg::REG_SP) begin
                            next_sp = imm20;
                        end else begin
                            next_regs[dst] = imm20;
                        end
                    end
                    eaie_pkg::OP_PUSH_SP_INC: begin
                        next_ptr = sp;
                        next_insn_done = 1'b0;
                        next_state = eaie_pkg::S_RD_LO;
                    end
                    eaie_pkg::OP_CALL_PC: begin
                        // pc is already past the call word, so both uses agree
                        next_data20 = pc;
                        next_target = pc;
                        next_do_jump = 1'b1;
                        next_sp = sp - eaie_pkg::PUSH_STEP;
                        next_insn_done = 1'b0;
                        next_state = eaie_pkg::S_WR_LO;
                    end
                    eaie_pkg::OP_CALL_IDX_SP: begin
                        // no history of the previous push enters the index
                        next_ptr = eaie_pkg::addr_plus(sp, sext_idx);
                        next_insn_done = 1'b0;
                        next_state = eaie_pkg::S_RD_LO;
                    end
                    eaie_pkg::OP_LPM_IDX: begin
                        next_low_power = iw1[eaie_pkg::LPM_BIT];
                        if (iw1[eaie_pkg::LPM_BIT]) begin
                            next_state = eaie_pkg::S_SLEEP;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            eaie_pkg::S_RD_LO, eaie_pkg::S_RD_HI: begin
                if (!mem_req) begin
                    next_mem_req = 1'b1;
                    next_mem_we = 1'b0;
                    next_mem_addr = (state == eaie_pkg::S_RD_LO) ? ptr :
                                    eaie_pkg::addr_plus(ptr, eaie_pkg::WORD_STEP);
                end else if (mem_ack) begin
                    next_mem_req = 1'b0;
                    if (state == eaie_pkg::S_RD_LO) begin
                        next_data20 = {data20[19:16], mem_rdata};
                        next_state = eaie_pkg::S_RD_HI;
                    end else begin
                        // read value never lands in sp; sp only steps down
                        next_sp = sp - eaie_pkg::PUSH_STEP;
                        next_state = eaie_pkg::S_WR_LO;
                        if (op == eaie_pkg::OP_PUSH_SP_INC) begin
                            next_data20 = {mem_rdata[eaie_pkg::HIW-1:0], data20[15:0]};
                            next_do_jump = 1'b0;
                        end else begin
                            next_target = {mem_rdata[eaie_pkg::HIW-1:0], data20[15:0]};
                            next_data20 = pc;
                            next_do_jump = 1'b1;
                        end
                    end
                end
            end
            eaie_pkg::S_WR_LO, eaie_pkg::S_WR_HI: begin
                if (!mem_req) begin
                    next_mem_req = 1'b1;
                    next_mem_we = 1'b1;
                    if (state == eaie_pkg::S_WR_LO) begin
                        next_mem_addr = sp;
                        next_mem_wdata = data20[15:0];
                    end else begin
                        next_mem_addr = eaie_pkg::addr_plus(sp, eaie_pkg::WORD_STEP);
                        next_mem_wdata = {{(eaie_pkg::DW - eaie_pkg::HIW){1'b0}}, data20[19:16]};
                    end
                end else if (mem_ack) begin
                    next_mem_req = 1'b0;
                    next_mem_we = 1'b0;
                    if (state == eaie_pkg::S_WR_LO) begin
                        next_state = eaie_pkg::S_WR_HI;
                    end else begin
                        next_state = eaie_pkg::S_FETCH;
                        // an interrupt entry is not an instruction of the program
                        next_insn_done = !(do_jump && target == eaie_pkg::NMI_VECTOR && nmi_entry);
                        next_prefix = 1'b0;
                        if (do_jump) begin
                            next_pc = target;
                        end
                    end
                end
            end
            eaie_pkg::S_SLEEP: begin
                if (take_nmi) begin
                    next_prefix = 1'b0;
                    next_low_power = 1'b0;
                    next_data20 = pc;
                    next_target = eaie_pkg::NMI_VECTOR;
                    next_do_jump = 1'b1;
                    next_nmi_ack = 1'b1;
                    next_sp = sp - eaie_pkg::PUSH_STEP;
                    next_state = eaie_pkg::S_WR_LO;
                end
            end
            default: begin
                next_state = eaie_pkg::S_FETCH;
            end
        endcase
    end

    always_comb begin
        next_nmi_entry = nmi_entry;
        if (next_nmi_ack) begin
            next_nmi_entry = 1'b1;
        end else if (state == eaie_pkg::S_EXEC) begin
            next_nmi_entry = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            state <= eaie_pkg::S_FETCH;
            for (int i = 0; i < 16; i++) begin
                regs[i] <= 20'h00000;
            end
            pc <= eaie_pkg::RESET_PC;
            sp <= eaie_pkg::RESET_SP;
            iw0 <= 16'h0000;
            iw1 <= 16'h0000;
            data20 <= 20'h00000;
            target <= 20'h00000;
            ptr <= 20'h00000;
            prefix <= 1'b0;
            do_jump <= 1'b0;
            low_power <= 1'b0;
            mem_req <= 1'b0;
            mem_we <= 1'b0;
            mem_addr <= 20'h00000;
            mem_wdata <= 16'h0000;
            nmi_ack <= 1'b0;
            insn_done <= 1'b0;
            flag_z <= 1'b0;
            flag_n <= 1'b0;
            flag_c <= 1'b0;
            nmi_entry <= 1'b0;
        end else begin
            state <= next_state;
            regs <= next_regs;
            pc <= next_pc;
            sp <= next_sp;
            iw0 <= next_iw0;
            iw1 <= next_iw1;
            data20 <= next_data20;
            target <= next_target;
            ptr <= next_ptr;
            prefix <= next_prefix;
            do_jump <= next_do_jump;
            low_power <= next_low_power;
            mem_req <= next_mem_req;
            mem_we <= next_mem_we;
            mem_addr <= next_mem_addr;
            mem_wdata <= next_mem_wdata;
            nmi_ack <= next_nmi_ack;
            insn_done <= next_insn_done;
            flag_z <= next_flag_z;
            flag_n <= next_flag_n;
            flag_c <= next_flag_c;
            nmi_entry <= next_nmi_entry;
        end
    end
endmodule // eaie_core
`default_nettype wire

// >>> eaie_core_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module eaie_monitor (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // memory port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    input wire logic [15:0] mem_rdata,
    input wire logic mem_ack,
    // non-maskable request and state
    input wire logic nmi_req,
    input wire logic nmi_ack,
    input wire logic [19:0] pc,
    input wire logic [19:0] sp,
    input wire logic low_power,
    input wire logic flag_z,
    input wire logic flag_n,
    input wire logic flag_c,
    input wire logic insn_done
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!nrst);

    a_req_stands: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
        else $error("memory request dropped or changed before ack");
    a_req_gap: assert property (mem_req && mem_ack |=> !mem_req)
        else $error("memory request not released after ack");
    a_done_pulse: assert property (insn_done |=> !insn_done)
        else $error("completion pulse longer than one cycle");
    a_nmi_pulse: assert property (nmi_ack |=> !nmi_ack)
        else $error("nmi ack longer than one cycle");
    a_nmi_cause: assert property (nmi_ack |-> $past(nmi_req))
        else $error("nmi ack without a request");
    a_nmi_stack: assert property (nmi_ack |-> sp == $past(sp) - 20'h00004)
        else $error("nmi entry did not lower sp by four");
    a_nmi_vector: assert property (nmi_ack |-> ##[1:40] pc == eaie_pkg::NMI_VECTOR)
        else $error("handler not entered after nmi ack");
    a_nmi_wake: assert property (nmi_ack |-> ##[1:40] !low_power)
        else $error("still sleeping after nmi entry");
    a_push_high: assert property (mem_req && mem_we && mem_addr == sp + 20'h00002
        |-> mem_wdata[15:4] == 12'h000)
        else $error("pushed high word carries bits above 19");

    c_nmi: cover property (nmi_ack);
    c_write: cover property (mem_req && mem_we && mem_ack);
    c_sleep: cover property (low_power);
endmodule // eaie_monitor

bind eaie_core eaie_monitor i_mon (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack),
    .nmi_req(nmi_req),
    .nmi_ack(nmi_ack),
    .pc(pc),
    .sp(sp),
    .low_power(low_power),
    .flag_z(flag_z),
    .flag_n(flag_n),
    .flag_c(flag_c),
    .insn_done(insn_done)
);
`default_nettype wire

// >>> eaie_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module eaie_mem (
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // memory port
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [19:0] mem_addr,
    input wire logic [15:0] mem_wdata,
    output logic [15:0] mem_rdata,
    output logic mem_ack,
    // extra wait cycles before each ack
    input wire logic [1:0] wait_cycles
);
    // 128 KiB so that an unsigned index escapes past 0x0ffff
    logic [15:0] m [0:65535];
    logic [1:0] cnt;

    // plain always: the bench preloads m between runs
    always @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mem_ack <= 1'b0;
            cnt <= 2'h0;
            mem_rdata <= 16'h0000;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            // released bus shows no stale word
            mem_rdata <= ~mem_rdata;
        end else if (mem_req && cnt == wait_cycles) begin
            mem_ack <= 1'b1;
            cnt <= 2'h0;
            mem_rdata <= m[mem_addr[16:1]];
            if (mem_we)
                m[mem_addr[16:1]] <= mem_wdata;
        end else if (mem_req) begin
            cnt <= cnt + 2'h1;
        end
    end
endmodule // eaie_mem
`default_nettype wire

// >>> test_extended_address_insn_exec.sv
`timescale 1ns/100ps
`default_nettype none
module test_extended_address_insn_exec;
    logic sys_clk, nrst, nmi_req, mem_req, mem_we, mem_ack, nmi_ack;
    logic low_power, flag_z, flag_n, flag_c, insn_done;
    logic [19:0] mem_addr, pc, sp;
    logic [15:0] mem_wdata, mem_rdata;
    logic [1:0] wait_cycles;
    int bad_count = 0;
    int n_compared = 0;
    int cycles = 0;

    eaie_core i_dut (
        .sys_clk(sys_clk), .nrst(nrst),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack),
        .nmi_req(nmi_req), .nmi_ack(nmi_ack),
        .pc(pc), .sp(sp), .low_power(low_power),
        .flag_z(flag_z), .flag_n(flag_n), .flag_c(flag_c), .insn_done(insn_done)
    );
    eaie_mem i_mem (
        .sys_clk(sys_clk), .nrst(nrst),
        .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata), .mem_ack(mem_ack), .wait_cycles(wait_cycles)
    );

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [19:0] got, input logic [19:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    function automatic logic [19:0] rd(input logic [19:0] a);
        return {4'h0, i_mem.m[a[16:1]]};
    endfunction

    task automatic put(input logic [19:0] a, input logic [15:0] d);
        i_mem.m[a[16:1]] = d;
    endtask

    // reset for 5 cycles, memory cleared to nop
    task automatic start(input logic [1:0] w);
        @(posedge sys_clk) nrst <= 1'b0;
        wait_cycles <= w;
        for (int i = 0; i < 65536; i++) i_mem.m[i] = 16'h0000;
        repeat (5) @(posedge sys_clk);
    endtask

    task automatic go();
        @(posedge sys_clk) nrst <= 1'b1;
    endtask

    task automatic wait_done(input int n);
        for (int k = 0; k < 400 && n > 0; k++) begin
            @(posedge sys_clk);
            #1;
            if (insn_done === 1'b1) n--;
        end
        chk(20'(n), 20'h0, "completions missing");
    endtask

    // word0: opcode nibble, imm high nibble, dst register
    task automatic t_pc_imm();
        logic [3:0] op [4] = '{eaie_pkg::OP_ADD_IMM, eaie_pkg::OP_SUB_IMM,
                               eaie_pkg::OP_CMP_IMM, eaie_pkg::OP_CMP_IMM};
        logic [15:0] imm [4] = '{16'h0010, 16'h0002, 16'h0004, 16'h0008};
        logic [19:0] exp [4] = '{20'h00014, 20'h00002, 20'h00004, 20'h00004};
        // expected sign and carry (no-borrow for sub and compare) of pc against the immediate
        logic [1:0] flg [4] = '{2'h0, 2'h1, 2'h1, 2'h2};
        for (int i = 0; i < 4; i++) begin
            start(2'(i));
            put(20'h0, {op[i], 8'h00, eaie_pkg::REG_PC});
            put(20'h2, imm[i]);
            go();
            wait_done(1);
            chk(pc, exp[i], "pc after immediate op");
            chk(20'(flag_z), 20'(i == 2), "zero flag");
            chk(20'({flag_n, flag_c}), 20'(flg[i]), "sign and carry flags");
        end
    endtask

    // nmi at the first edge after reset; handler keeps a nop first
    task automatic t_nmi_run();
        start(2'h2);
        put(20'hff00, 16'h0000);
        go();
        nmi_req <= 1'b1;
        @(posedge sys_clk);
        #1;
        chk(20'(nmi_ack), 20'h1, "nmi at first edge");
        @(posedge sys_clk) nmi_req <= 1'b0;
        wait_done(1);
        chk(pc, 20'h0ff02, "pc after handler nop");
        chk(sp, 20'h00ffc, "sp after nmi entry");
        chk(rd(20'h0ffc), 20'h00000, "nmi return at reset");
    endtask

    task automatic t_prefix_mov();
        start(2'h1);
        put(20'h0, 16'h9000);
        put(20'h2, 16'h1000);
        put(20'h4, 16'h0010);
        put(20'h16, 16'h4100);
        put(20'h18, 16'h2345);
        go();
        wait_done(1);
        chk(pc, 20'h00016, "pc after prefixed add");
        wait_done(1);
        chk(pc, 20'h12345, "pc after move");
    endtask

    // push from @sp+ then call with index -4 on sp
    task automatic t_push_call();
        start(2'h3);
        put(20'h0, 16'h5001);
        put(20'h2, 16'h7001);
        put(20'h4, 16'hfffc);
        put(20'h0ff8, 16'h0100);
        put(20'h1000, 16'hbeef);
        put(20'h1002, 16'h0003);
        go();
        wait_done(1);
        chk(sp, 20'h00ffc, "sp after push");
        chk(rd(20'h0ffc), 20'h0beef, "pushed low word");
        chk(rd(20'h0ffe), 20'h00003, "pushed high word");
        wait_done(1);
        chk(pc, 20'h00100, "pc after indexed call");
        chk(sp, 20'h00ff8, "sp after indexed call");
        chk(rd(20'h0ff8), 20'h00006, "indexed call return");
    endtask

    task automatic t_call_pc();
        start(2'h0);
        put(20'h2, 16'h6000);
        go();
        wait_done(2);
        chk(pc, 20'h00004, "pc after call through pc");
        chk(rd(20'h0ffc), 20'h00004, "return low word");
        chk(rd(20'h0ffe), 20'h00000, "return high word");
    endtask

    // sleep by OP_LPM_IDX with bit 4 of its second word set, prefix next, handler starts with 4-byte add
    task automatic t_nmi_sleep();
        start(2'h1);
        put(20'h0, 16'h8000);
        put(20'h2, 16'h0010);
        put(20'h4, 16'h9000);
        put(20'hff00, 16'h1000);
        put(20'hff02, 16'h0010);
        go();
        wait_done(1);
        chk(20'(low_power), 20'h1, "sleeping");
        @(posedge sys_clk) nmi_req <= 1'b1;
        for (int k = 0; k < 20 && nmi_ack !== 1'b1; k++) begin
            @(posedge sys_clk);
            #1;
        end
        chk(20'(nmi_ack), 20'h1, "nmi taken");
        @(posedge sys_clk) nmi_req <= 1'b0;
        wait_done(1);
        chk(pc, 20'h0ff14, "pc after handler add");
        chk(20'(low_power), 20'h0, "woken");
        chk(rd(20'h0ffc), 20'h00004, "nmi return address");
    endtask

    initial begin
        nrst = 1'b0;
        nmi_req = 1'b0;
        wait_cycles = 2'h0;
        t_pc_imm();
        t_prefix_mov();
        t_push_call();
        t_call_pc();
        t_nmi_sleep();
        t_nmi_run();
        wrap_up();
    end
endmodule // test_extended_address_insn_exec
`default_nettype wire
